// *** core/cncs_consts.vh ***
`ifndef CNCS_CONSTS_VH
`define CNCS_CONSTS_VH
// Register byte addresses of the profile 1 tuning word, LSB first
`define CNCS_ADDR_TW_B0 5'h02
`define CNCS_ADDR_TW_B1 5'h03
`define CNCS_ADDR_TW_B2 5'h04
`define CNCS_ADDR_TW_B3 5'h05
// Control byte holding bypass and multiplier fields
`define CNCS_ADDR_CTRL 5'h06
`define CNCS_CTRL_BYPASS_BIT 0
`define CNCS_CTRL_MULT_EN_BIT 1
`define CNCS_CTRL_MULT_LSB 2
`define CNCS_CTRL_MULT_MSB 6
// Status byte: multiplier valid flag and fifo fill state
`define CNCS_ADDR_STATUS 5'h07
// Reset values
`define CNCS_TW_RESET 32'h0000_0000
`define CNCS_CTRL_RESET 8'h00
// Multiplier legal range
`define CNCS_MULT_MIN 5'h04
`define CNCS_MULT_MAX 5'h14
// Filter pipeline latency in samples (centre tap plus output register)
`define CNCS_FIR_LAT 4'h9
// Sine table index width
`define CNCS_LUT_AW 8
`endif

// *** core/cncs_fifo.v ***
`timescale 1ns/1ps
// Sample FIFO, power-of-two depth
module cncs_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [AW:0] wr_ptr; // Extra bit tells full from empty
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  // Pointer and storage update
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// *** core/cncs_top.v ***
`timescale 1ns/1ps
`include "cncs_consts.vh"
module cncs_top #(
  parameter DW = 12,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire rst,
  // Byte-wide register port from the serial controller
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata,
  // Modulated sample stream from the upstream datapath
  input wire [DW-1:0] in_sample,
  input wire in_valid,
  output wire in_ready,
  // Carriers toward the modulator
  output reg [DW-1:0] carrier_sin,
  output reg [DW-1:0] carrier_cos,
  // Converter word
  output reg [DW-1:0] dac_word,
  // Multiplier setting toward the analog PLL
  output reg [4:0] ref_mult_factor,
  output reg ref_mult_enable
);
  reg [31:0] carrier_tuning_word; // Profile 1 tuning word
  reg [7:0] ctrl; // Bypass, multiplier enable, factor
  reg [31:0] phase_acc; // Oscillator phase
  reg [DW-1:0] sin_tab [0:(1<<`CNCS_LUT_AW)-1]; // Full-cycle sine table
  reg [DW-1:0] taps [0:16]; // Filter delay line
  reg signed [DW+9:0] next_acc; // Filter sum, wide to hold coefficient growth
  reg [DW-1:0] fir_out; // Saturated filter result
  wire signed [DW+1:0] fir_scaled; // Sum with the coefficient scale removed
  wire signed [DW:0] pair_sum [1:8]; // Folded sums of mirrored taps
  wire [DW-1:0] fifo_data; // Head of the sample buffer
  wire fifo_valid; // Buffer holds a sample
  wire [4:0] mult_req; // Factor field as written
  wire mult_ok; // Factor inside the legal range
  wire bypass; // Filter bypass select
  integer i; // Table build index
  integer j; // Delay line index
  integer sin_val; // One table entry before narrowing
  // Inverse-sinc coefficients, scaled by 256, centre first.
  // Odd taps pull down and even taps except the unused eighth push up, so the gain rises toward
  // half the sample rate by about the reciprocal of the hold droop.
  // Their sum, 179/256, sets the fixed insertion loss near 3.1 dB.
  localparam signed [9:0] FIR_C0 = 10'sh0d5;
  localparam signed [9:0] FIR_C1 = -10'sh014;
  localparam signed [9:0] FIR_C2 = 10'sh006;
  localparam signed [9:0] FIR_C3 = -10'sh004;
  localparam signed [9:0] FIR_C4 = 10'sh002;
  localparam signed [9:0] FIR_C5 = -10'sh001;
  localparam signed [9:0] FIR_C6 = 10'sh001;
  localparam signed [9:0] FIR_C7 = -10'sh001;
  localparam signed [9:0] FIR_C8 = 10'sh000; // Outer pair unused, kept for 17 taps
  // Converter word limits, sign-extended to the scaled sum width
  localparam signed [DW+1:0] FIR_MAX = {3'b000, {(DW-1){1'b1}}};
  localparam signed [DW+1:0] FIR_MIN = {3'b111, {(DW-1){1'b0}}};
  assign bypass = ctrl[`CNCS_CTRL_BYPASS_BIT];
  assign mult_req = ctrl[`CNCS_CTRL_MULT_MSB:`CNCS_CTRL_MULT_LSB];
  assign mult_ok = (mult_req >= `CNCS_MULT_MIN) && (mult_req <= `CNCS_MULT_MAX);
  // Table built once; a constant ROM, two's complement samples
  // Truncation toward zero keeps the table odd about the half turn
  initial begin
    for (i = 0; i < (1<<`CNCS_LUT_AW); i = i + 1) begin
      sin_val = $rtoi(2047.0 * $sin(6.283185307 * i / (1<<`CNCS_LUT_AW)));
      sin_tab[i] = sin_val[DW-1:0];
    end
  end
  // Stream buffer; drained one sample per clock whenever data waits
  // The drain never stalls, so the buffer only absorbs bursts
  // that outrun one sample per clock
  cncs_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) cncs_fifo_inst (
    .clk(clk),
    .rst(rst),
    .in_data(in_sample),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(1'b1)
  );
  // Register writes; address 2 is least significant byte
  // Each byte lands on its own, so a multi-byte change passes
  // through mixed words for a few clocks
  always @(posedge clk) begin
    if (rst) begin
      carrier_tuning_word <= `CNCS_TW_RESET;
      ctrl <= `CNCS_CTRL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `CNCS_ADDR_TW_B0: carrier_tuning_word[7:0] <= reg_wdata;
        `CNCS_ADDR_TW_B1: carrier_tuning_word[15:8] <= reg_wdata;
        `CNCS_ADDR_TW_B2: carrier_tuning_word[23:16] <= reg_wdata;
        `CNCS_ADDR_TW_B3: carrier_tuning_word[31:24] <= reg_wdata;
        `CNCS_ADDR_CTRL: ctrl <= reg_wdata;
        default: ctrl <= ctrl; // Unmapped writes ignored
      endcase
    end
  end
  // Register reads, combinational; unmapped reads as zero
  // Status: bit 2 buffer not empty, bit 1 buffer full, bit 0 factor legal
  always @* begin
    case (reg_addr)
      `CNCS_ADDR_TW_B0: reg_rdata = carrier_tuning_word[7:0];
      `CNCS_ADDR_TW_B1: reg_rdata = carrier_tuning_word[15:8];
      `CNCS_ADDR_TW_B2: reg_rdata = carrier_tuning_word[23:16];
      `CNCS_ADDR_TW_B3: reg_rdata = carrier_tuning_word[31:24];
      `CNCS_ADDR_CTRL: reg_rdata = ctrl;
      `CNCS_ADDR_STATUS: reg_rdata = {5'h00, fifo_valid, !in_ready, mult_ok};
      default: reg_rdata = 8'h00;
    endcase
  end
  // Multiplier outputs; illegal factor keeps PLL disabled
  // Factor output holds its last legal value, so the loop
  // never sees an out-of-range divide
  always @(posedge clk) begin
    if (rst) begin
      ref_mult_factor <= `CNCS_MULT_MIN;
      ref_mult_enable <= 1'b0;
    end else if (mult_ok) begin
      ref_mult_factor <= mult_req;
      ref_mult_enable <= ctrl[`CNCS_CTRL_MULT_EN_BIT];
    end else begin
      ref_mult_enable <= 1'b0;
    end
  end
  // Phase accumulator; wraps mod 2^32 so f = word*clk/2^32
  // Only the top eight bits address the table; the rest keep fine steps
  always @(posedge clk) begin
    if (rst) begin
      phase_acc <= 32'h0000_0000;
    end else begin
      phase_acc <= phase_acc + carrier_tuning_word;
    end
  end
  // Carrier lookup; cosine is sine advanced a quarter turn
  // Both carriers read one table, so their amplitudes match exactly
  always @(posedge clk) begin
    if (rst) begin
      carrier_sin <= {DW{1'b0}};
      carrier_cos <= {DW{1'b0}};
    end else begin
      carrier_sin <= sin_tab[phase_acc[31:24]];
      carrier_cos <= sin_tab[phase_acc[31:24] + 8'h40];
    end
  end
  // Delay line shifts every clock; empty fifo feeds zero
  // Zero fill lets an idle stream drain the filter to silence
  always @(posedge clk) begin
    if (rst) begin
      for (j = 0; j < 17; j = j + 1) taps[j] <= {DW{1'b0}};
    end else begin
      taps[0] <= fifo_valid ? fifo_data : {DW{1'b0}};
      for (j = 1; j < 17; j = j + 1) taps[j] <= taps[j-1];
    end
  end
  // Folded pre-adders; mirrored taps share one coefficient
  genvar p;
  generate
    for (p = 1; p <= 8; p = p + 1) begin : g_fold
      assign pair_sum[p] = $signed(taps[8-p]) + $signed(taps[8+p]);
    end
  endgenerate
  // Symmetric inverse-sinc sum over the centre and eight pairs.
  // Equal coefficients on mirrored taps keep the phase linear.
  always @* begin
    next_acc = $signed(taps[8]) * FIR_C0;
    next_acc = next_acc + pair_sum[1] * FIR_C1;
    next_acc = next_acc + pair_sum[2] * FIR_C2;
    next_acc = next_acc + pair_sum[3] * FIR_C3;
    next_acc = next_acc + pair_sum[4] * FIR_C4;
    next_acc = next_acc + pair_sum[5] * FIR_C5;
    next_acc = next_acc + pair_sum[6] * FIR_C6;
    next_acc = next_acc + pair_sum[7] * FIR_C7;
    next_acc = next_acc + pair_sum[8] * FIR_C8;
  end
  // Drop the coefficient scale; two guard bits remain for the clamp
  assign fir_scaled = next_acc[DW+9:8];
  // Filter output register with saturation to the word width
  // Gain above one near half rate can overflow a full-scale input
  always @(posedge clk) begin
    if (rst) begin
      fir_out <= {DW{1'b0}};
    end else begin
      if (fir_scaled > FIR_MAX) begin
        fir_out <= FIR_MAX[DW-1:0]; // Clamp high
      end else if (fir_scaled < FIR_MIN) begin
        fir_out <= FIR_MIN[DW-1:0]; // Clamp low
      end else begin
        fir_out <= fir_scaled[DW-1:0]; // In range
      end
    end
  end
  // Converter word; bypass takes fifo head with no filter delay
  // Switching mid-stream drops or repeats up to a filter delay of samples
  // The bypass path needs no clamp; samples already fit the word
  always @(posedge clk) begin
    if (rst) begin
      dac_word <= {DW{1'b0}};
    end else if (bypass) begin
      dac_word <= fifo_valid ? fifo_data : {DW{1'b0}};
    end else begin
      dac_word <= fir_out;
    end
  end
endmodule

// *** tb/cncs_properties.sv ***
`timescale 1ns/1ps
// Port-level checker; shadows of written fields give expectations
module cncs_properties #(
  parameter DW = 12
) (
  input wire clk,
  input wire rst,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [7:0] reg_rdata,
  input wire [DW-1:0] in_sample,
  input wire in_valid,
  input wire in_ready,
  input wire [DW-1:0] carrier_sin,
  input wire [DW-1:0] carrier_cos,
  input wire [DW-1:0] dac_word,
  input wire [4:0] ref_mult_factor,
  input wire ref_mult_enable
);
  reg [31:0] tw; // Shadow tuning word
  reg bypass; // Shadow bypass bit
  reg [2:0] age; // Cycles since a tuning or control write, so switch-over is skipped
  reg [4:0] idle; // Cycles without input
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow registers
  always @(posedge clk) begin
    if (rst) begin
      tw <= 32'h0000_0000;
      bypass <= 1'b0;
      age <= 3'h0;
    end else if (reg_wr && reg_addr >= 5'h02 && reg_addr <= 5'h06) begin
      age <= 3'h0;
      if (reg_addr == 5'h06) bypass <= reg_wdata[0];
      else tw[{reg_addr[1:0] - 2'h2, 3'h0} +: 8] <= reg_wdata;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  // Idle run length
  always @(posedge clk) begin
    if (rst || in_valid) idle <= 5'h00;
    else if (idle != 5'h1f) idle <= idle + 5'h01;
  end
  chk_mult_legal: assert property (
    ref_mult_enable |-> ref_mult_factor >= 5'h04 && ref_mult_factor <= 5'h14)
    else $error("multiplier on with bad factor");
  chk_reset_mult: assert property (disable iff (1'b0)
    rst |=> ref_mult_factor == 5'h04 && !ref_mult_enable) else $error("multiplier reset");
  chk_tw_readback: assert property (
    reg_wr && reg_addr >= 5'h02 && reg_addr <= 5'h05 ##1 !reg_wr && $stable(reg_addr)
    |-> reg_rdata == $past(reg_wdata)) else $error("tuning byte readback");
  chk_carrier_bound: assert property (
    carrier_sin != 12'h800 && carrier_cos != 12'h800) else $error("carrier amplitude");
  chk_quad_phase: assert property (
    age == 3'h7 && tw == 32'h4000_0000 |-> carrier_sin == $past(carrier_cos))
    else $error("carrier quadrature");
  chk_phase_hold: assert property (
    age == 3'h7 && tw == 32'h0 |-> $stable(carrier_sin) && $stable(carrier_cos))
    else $error("phase moved at zero word");
  chk_bypass_path: assert property (
    age == 3'h7 && bypass && $past(in_valid && in_ready, 2)
    |-> dac_word == $past(in_sample, 2)) else $error("bypass latency");
  chk_dac_quiet: assert property (
    idle == 5'h1f |-> dac_word == 12'h000) else $error("output without input");
endmodule
bind cncs_top cncs_properties #(.DW(DW)) cncs_properties_inst (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready),
  .carrier_sin(carrier_sin), .carrier_cos(carrier_cos), .dac_word(dac_word),
  .ref_mult_factor(ref_mult_factor), .ref_mult_enable(ref_mult_enable));

// *** tb/cncs_src.sv ***
`timescale 1ns/1ps
// Upstream sample source; idle data is the inverse of the last word
module cncs_src (
  input wire clk,
  input wire in_ready,
  output reg [11:0] in_sample,
  output reg in_valid
);
  initial begin
    in_sample = 12'h000;
    in_valid = 1'b0;
  end
  // One sample, held until taken
  task send(input [11:0] s);
    begin
      @(posedge clk);
      #1;
      in_sample = s;
      in_valid = 1'b1;
      while (in_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk);
      #1;
      in_valid = 1'b0;
      in_sample = ~s;
    end
  endtask
endmodule

// *** tb/cncs_top_tb.sv ***
`timescale 1ns/1ps
module cncs_top_tb;
  reg clk, rst, reg_wr;
  reg [4:0] reg_addr;
  reg [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire [11:0] in_sample, carrier_sin, carrier_cos, dac_word;
  wire in_valid, in_ready, ref_mult_enable;
  wire [4:0] ref_mult_factor;
  integer n_errors, check_count, i, k, km, dc, ny;
  reg [11:0] cap [0:39]; // Captured words
  localparam [31:0] TWV = 32'h556a_aaab;
  localparam [19:0] FT = {5'h15, 5'h14, 5'h04, 5'h03}; // Factors across the range
  cncs_top cncs_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .in_sample(in_sample), .in_valid(in_valid),
    .in_ready(in_ready), .carrier_sin(carrier_sin), .carrier_cos(carrier_cos),
    .dac_word(dac_word), .ref_mult_factor(ref_mult_factor), .ref_mult_enable(ref_mult_enable));
  cncs_src cncs_src_inst (.clk(clk), .in_ready(in_ready), .in_sample(in_sample),
    .in_valid(in_valid));
  task chk(input [8*8-1:0] what, input [11:0] e, input [11:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [7:0] e);
    begin
      @(posedge clk);
      #1;
      reg_addr = a;
      #1;
      chk("rdata", e, reg_rdata);
    end
  endtask
  task grab;
    for (k = 0; k < 40; k = k + 1) begin
      @(posedge clk);
      #1;
      cap[k] = dac_word;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog well beyond the couple of hundred cycles of the tests
  initial begin
    #40000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    {rst, reg_wr, reg_addr, reg_wdata, n_errors, check_count} = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 2; i < 8; i = i + 1) rd(i, 8'h00);
    chk("factor", 12'h004, ref_mult_factor);
    repeat (8) @(posedge clk);
    #1;
    chk("cos", 12'h7ff, carrier_cos);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(i + 2, TWV[8*i +: 8]);
      rd(i + 2, TWV[8*i +: 8]);
    end
    wr(5'h1f, 8'hff);
    rd(5'h02, 8'hab);
    for (i = 0; i < 4; i = i + 1) wr(i + 2, (i == 3) ? 8'h40 : 8'h00);
    repeat (8) @(posedge clk);
    for (k = 0; k < 5; k = k + 1) begin
      @(posedge clk);
      #1;
      cap[k] = carrier_sin;
      cap[k+8] = carrier_cos;
    end
    chk("period", cap[0], cap[4]);
    chk("half", -cap[1], cap[3]);
    chk("quad", cap[8], cap[1]);
    $display("test carrier done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(5'h06, {1'b0, FT[5*i +: 5], 2'h2});
      rd(5'h06, {1'b0, FT[5*i +: 5], 2'h2});
      @(posedge clk);
      #1;
      chk("enable", (i == 1 || i == 2), ref_mult_enable);
      chk("factor", (i >= 2) ? 12'h014 : 12'h004, ref_mult_factor);
      rd(5'h07, {7'h00, (i == 1 || i == 2)});
    end
    $display("test multiplier done");
    wr(5'h06, 8'h01);
    repeat (8) @(posedge clk);
    cncs_src_inst.send(12'h5a3);
    for (k = 0; k < 4 && dac_word !== 12'h5a3; k = k + 1) @(posedge clk) #1;
    chk("bypass", 12'h5a3, dac_word);
    $display("test bypass done");
    wr(5'h06, 8'h00);
    repeat (40) @(posedge clk);
    cncs_src_inst.send(12'h400);
    grab;
    km = 0;
    for (k = 1; k < 40; k = k + 1) if ($signed(cap[k]) > $signed(cap[km])) km = k;
    chk("centre", 12'h354, cap[km]);
    chk("tap1", 12'hfb0, cap[km+1]);
    dc = 0;
    ny = 0;
    for (i = -8; i < 9; i = i + 1) begin
      dc = dc + $signed(cap[km+i]);
      ny = ny + (((i % 2) != 0) ? -$signed(cap[km+i]) : $signed(cap[km+i]));
    end
    chk("dcgain", 12'h2cc, dc[11:0]);
    chk("nyquist", 12'h46c, ny[11:0]);
    for (i = 1; i < 9; i = i + 1) chk("mirror", cap[km-i], cap[km+i]);
    chk("tail", 12'h000, cap[km+9]);
    $display("test filter done");
    results;
  end
endmodule
